/* File: design/otc_params.svh */
// constants of the odd timer control block: offsets, bit positions, ratios
// assumes nothing; definitions only
`ifndef OTC_PARAMS_SVH
`define OTC_PARAMS_SVH

// ==========================================================
// register byte offsets
`define OTC_OFS_CTRL 4'h0
`define OTC_OFS_COUNT 4'h4
`define OTC_OFS_STATUS 4'h8

// ==========================================================
// control register bit positions
`define OTC_BIT_RUN 15
`define OTC_BIT_IDLE 13
`define OTC_BIT_GATE 6
`define OTC_BIT_PSHI 5
`define OTC_BIT_PSLO 4
`define OTC_BIT_CS 1
`define OTC_CTRL_MASK 16'ha072
`define OTC_CTRL_RESET 16'h0000
`define OTC_COUNT_RESET 16'h0000

// ==========================================================
// prescale ratios minus one
`define OTC_DIV1_M1 8'h00
`define OTC_DIV8_M1 8'h07
`define OTC_DIV64_M1 8'h3f
`define OTC_DIV256_M1 8'hff

// ==========================================================
// bus answers
`define OTC_RESP_OKAY 2'h0
`define OTC_RESP_SLVERR 2'h2

`endif

/* File: design/otc_pkg.sv */
// state types of the odd timer control block
// assumes otc_params.svh is included where constants are needed
package otc_pkg;

  // ==========================================================
  // prescaler state
  typedef struct packed {
    logic [7:0] cnt;
    logic tick;
  } otc_presc_s;

  // ==========================================================
  // top state: bus slave, control, count and pin synchronisers
  typedef struct packed {
    logic aw_rdy;
    logic aw_have;
    logic [3:0] aw_addr;
    logic w_rdy;
    logic w_have;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic ar_rdy;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [15:0] ctrl;
    logic [15:0] count;
    logic [2:0] ext_sync;
    logic [1:0] gate_sync;
    logic active;
    logic wide;
  } otc_top_s;

endpackage

/* File: design/otc_prescaler.sv */
// four-step input prescaler: passes one tick in 1, 8, 64 or 256
// assumes tick_in is sampled on clk and counts once per high cycle, so it may be held high; clear restarts the division
`timescale 1ns/1ns
`include "otc_params.svh"

module otc_prescaler (
  input wire logic clk,
  input wire logic rst,
  input wire logic tick_in,
  input wire logic clear,
  input wire logic [1:0] sel,
  output logic tick_out
);

  otc_pkg::otc_presc_s s_r;
  otc_pkg::otc_presc_s s_nxt;
  logic [7:0] limit;

  // ==========================================================
  // division
  always_comb begin
    case (sel)
      2'h0: limit = `OTC_DIV1_M1;
      2'h1: limit = `OTC_DIV8_M1;
      2'h2: limit = `OTC_DIV64_M1;
      2'h3: limit = `OTC_DIV256_M1;
      default: limit = `OTC_DIV1_M1;
    endcase
    s_nxt = s_r;
    s_nxt.tick = 1'b0;
    if (clear) begin
      s_nxt.cnt = 8'h00;
    end else if (tick_in) begin
      if (s_r.cnt >= limit) begin
        s_nxt.cnt = 8'h00;
        s_nxt.tick = 1'b1;
      end else begin
        s_nxt.cnt = s_r.cnt + 8'h01;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign tick_out = s_r.tick;

endmodule

/* File: design/otc_top.sv */
// odd timer control: control register, prescaler, clock choice and 16-bit count
// assumes AXI4-Lite master on clk; pins are asynchronous; idle_mode is on clk
//
// The implementer's own choices: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/1ns
`include "otc_params.svh"

module otc_top (
  input wire logic clk,
  input wire logic rst,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic idle_mode,
  input wire logic ext_count_pin,
  input wire logic gate_pin,
  input wire logic pair_wide_enable,
  input wire logic partner_run_on,
  input wire logic partner_gate_accumulate,
  input wire logic [1:0] partner_prescale_select,
  input wire logic partner_clock_source_select,
  output logic [15:0] timer_count,
  output logic timer_active
);

  otc_pkg::otc_top_s s_r;
  otc_pkg::otc_top_s s_nxt;
  logic presc_tick;
  logic presc_in;
  logic presc_clear;
  logic eff_run;
  logic eff_gate;
  logic [1:0] eff_ps;
  logic eff_cs;
  logic halted;
  logic ext_rise;
  logic src_tick;
  logic [15:0] ctrl_wr;

  // ==========================================================
  // effective controls
  always_comb begin
    // in wide mode the even partner owns these controls
    if (s_r.wide) begin
      eff_run = partner_run_on;
      eff_gate = partner_gate_accumulate;
      eff_ps = partner_prescale_select;
      eff_cs = partner_clock_source_select;
    end else begin
      eff_run = s_r.ctrl[`OTC_BIT_RUN];
      eff_gate = s_r.ctrl[`OTC_BIT_GATE];
      eff_ps = s_r.ctrl[`OTC_BIT_PSHI:`OTC_BIT_PSLO];
      eff_cs = s_r.ctrl[`OTC_BIT_CS];
    end
    // halt_in_idle stays ours even in wide mode
    halted = idle_mode & s_r.ctrl[`OTC_BIT_IDLE];
    ext_rise = s_r.ext_sync[1] & ~s_r.ext_sync[2];
    // the gate input only matters with the internal clock chosen
    if (eff_cs) begin
      src_tick = ext_rise;
    end else if (eff_gate) begin
      src_tick = s_r.gate_sync[1];
    end else begin
      src_tick = 1'b1;
    end
    presc_in = eff_run & ~halted & src_tick;
    // stopping restarts the division so a new run starts clean
    presc_clear = ~eff_run;
  end

  // ==========================================================
  // write data filtered to the implemented control bits
  // masking at the write keeps unimplemented positions zero in the flops too
  assign ctrl_wr = s_r.w_data[15:0] & `OTC_CTRL_MASK;

  otc_prescaler otc_prescaler_inst (
    .clk(clk),
    .rst(rst),
    .tick_in(presc_in),
    .clear(presc_clear),
    .sel(eff_ps),
    .tick_out(presc_tick)
  );

  // ==========================================================
  // next state
  always_comb begin
    s_nxt = s_r;
    // two flops before any logic reads a pin
    s_nxt.ext_sync = {s_r.ext_sync[1:0], ext_count_pin};
    s_nxt.gate_sync = {s_r.gate_sync[0], gate_pin};
    // partner mode is on clk already; one register keeps it off the bus path
    s_nxt.wide = pair_wide_enable;
    s_nxt.active = eff_run & ~halted;

    // count advances once per prescaled tick; a software write wins
    if (presc_tick) begin
      s_nxt.count = s_r.count + 16'h0001;
    end

    // write address and data are taken in either order
    if (s_axi_awvalid && s_r.aw_rdy) begin
      s_nxt.aw_have = 1'b1;
      s_nxt.aw_addr = s_axi_awaddr[3:0];
    end
    if (s_axi_wvalid && s_r.w_rdy) begin
      s_nxt.w_have = 1'b1;
      s_nxt.w_data = s_axi_wdata;
      s_nxt.w_strb = s_axi_wstrb;
    end
    if (s_r.bvalid && s_axi_bready) begin
      s_nxt.bvalid = 1'b0;
    end
    if (s_r.aw_have && s_r.w_have && !s_r.bvalid) begin
      s_nxt.aw_have = 1'b0;
      s_nxt.w_have = 1'b0;
      s_nxt.bvalid = 1'b1;
      s_nxt.bresp = `OTC_RESP_OKAY;
      case (s_r.aw_addr)
        `OTC_OFS_CTRL: begin
          // only implemented bits are stored
          if (s_r.w_strb[0]) begin
            s_nxt.ctrl[7:0] = ctrl_wr[7:0];
          end
          if (s_r.w_strb[1]) begin
            s_nxt.ctrl[15:8] = ctrl_wr[15:8];
          end
        end
        `OTC_OFS_COUNT: begin
          if (s_r.w_strb[0]) begin
            s_nxt.count[7:0] = s_r.w_data[7:0];
          end
          if (s_r.w_strb[1]) begin
            s_nxt.count[15:8] = s_r.w_data[15:8];
          end
        end
        `OTC_OFS_STATUS: begin
          // status is read-only: the write is answered and dropped
          s_nxt.bresp = `OTC_RESP_OKAY;
        end
        default: begin
          s_nxt.bresp = `OTC_RESP_SLVERR;
        end
      endcase
    end
    // readies stay low from a take until the write answer is accepted
    s_nxt.aw_rdy = ~s_nxt.aw_have & ~s_nxt.bvalid;
    s_nxt.w_rdy = ~s_nxt.w_have & ~s_nxt.bvalid;

    // read channel
    // data are captured at the address handshake and held until taken
    if (s_r.rvalid && s_axi_rready) begin
      s_nxt.rvalid = 1'b0;
    end
    if (s_axi_arvalid && s_r.ar_rdy) begin
      s_nxt.rvalid = 1'b1;
      s_nxt.rresp = `OTC_RESP_OKAY;
      case (s_axi_araddr[3:0])
        `OTC_OFS_CTRL: begin
          s_nxt.rdata = {16'h0000, s_r.ctrl & `OTC_CTRL_MASK};
        end
        `OTC_OFS_COUNT: begin
          s_nxt.rdata = {16'h0000, s_r.count};
        end
        `OTC_OFS_STATUS: begin
          s_nxt.rdata = {30'h0, s_r.wide, s_r.active};
        end
        default: begin
          s_nxt.rdata = 32'h00000000;
          s_nxt.rresp = `OTC_RESP_SLVERR;
        end
      endcase
    end
    s_nxt.ar_rdy = ~s_nxt.rvalid;
  end

  // ==========================================================
  // state register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign s_axi_awready = s_r.aw_rdy;
  assign s_axi_wready = s_r.w_rdy;
  assign s_axi_bvalid = s_r.bvalid;
  assign s_axi_bresp = s_r.bresp;
  assign s_axi_arready = s_r.ar_rdy;
  assign s_axi_rvalid = s_r.rvalid;
  assign s_axi_rdata = s_r.rdata;
  assign s_axi_rresp = s_r.rresp;
  assign timer_count = s_r.count;
  assign timer_active = s_r.active;

endmodule

/* File: bench/otc_top_props.sv */
// assertions on the ports of the odd timer control block
// assumes it is bound onto otc_top: one clock, asynchronous active-high reset
`timescale 1ns/1ns
module otc_props (
  input wire logic clk,
  input wire logic rst,
  input wire logic s_axi_awready,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [15:0] timer_count,
  input wire logic timer_active
);
  // ==========================================================
  // properties
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // awready up means no write was taken, so the count may only move by counting
  sequence s_quiet;
    !timer_active && s_axi_awready;
  endsequence
  a_reset_zero:
    assert property ($fell(rst) |-> timer_count == 16'h0 && !timer_active)
    else $error("count or active not clear after reset");
  a_count_step:
    assert property ($changed(timer_count) && $past(s_axi_awready) && s_axi_awready
      |-> timer_count == $past(timer_count) + 16'h1)
    else $error("count moved by other than one");
  a_stopped_frozen:
    assert property (s_quiet [*4] |-> $stable(timer_count))
    else $error("count moved while inactive");
  a_upper_zero:
    assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0)
    else $error("upper read bits not zero");
  a_err_no_data:
    assert property (s_axi_rvalid && s_axi_rresp == 2'h2 |-> s_axi_rdata == 32'h0)
    else $error("error read carries data");
  a_b_holds:
    assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer dropped early");
  a_r_holds:
    assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer dropped early");
  a_read_answer:
    assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
    else $error("read not answered next cycle");
  a_write_answer:
    assert property ($fell(s_axi_awready) && $fell(s_axi_wready) |-> ##[0:2] s_axi_bvalid)
    else $error("write not answered in time");
endmodule

bind otc_top otc_props otc_props_inst (.*);

/* File: bench/otc_top_tb.sv */
// self-checking bench of the odd timer control block
// assumes otc_top with an AXI4-Lite slave on clk; the bench is bus master
`timescale 1ns/1ns
`include "otc_params.svh"
module otc_top_tb;
  logic clk, rst, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
  logic s_axi_rready, idle_mode, ext_count_pin, gate_pin, pair_wide_enable, ext_run;
  logic partner_run_on, partner_gate_accumulate, partner_clock_source_select;
  logic timer_active;
  logic [1:0] s_axi_bresp, s_axi_rresp, partner_prescale_select;
  logic [3:0] s_axi_wstrb;
  logic [15:0] timer_count;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
  int miscompares = 0;
  int n_checks = 0;
  int dv[4] = '{1, 8, 64, 256};
  otc_top otc_top_inst (.*);
  initial begin
    clk = 0;
    forever #25 clk = ~clk;
  end
  // one rising pin edge every two cycles while ext_run is high, held low otherwise
  always @(posedge clk) ext_count_pin <= ext_run ? !ext_count_pin : 1'b0;
  // ==========================================================
  // checks and bus cycles
  task automatic stop_test;
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic guard(input int n);
    if (n >= 50) begin
      miscompares++;
      stop_test();
    end
  endtask
  task automatic chk(input logic [31:0] g, e);
    n_checks++;
    if (g !== e) begin
      miscompares++;
      $display("BAD t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [31:0] a, d);
    int n;
    n = 0;
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    while ((s_axi_awvalid || s_axi_wvalid || !s_axi_bvalid) && n < 50) begin
      @(posedge clk);
      n++;
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end
    guard(n);
    s_axi_bready <= 1'b1;
    @(posedge clk);
    chk(s_axi_bresp, 32'h0);
    s_axi_bready <= 1'b0;
  endtask
  task automatic rdchk(input logic [31:0] a, e, r);
    int n;
    n = 0;
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do begin @(posedge clk); n++; end while (!s_axi_arready && n < 50);
    s_axi_arvalid <= 1'b0;
    do begin @(posedge clk); n++; end while (!s_axi_rvalid && n < 50);
    guard(n);
    s_axi_rready <= 1'b1;
    @(posedge clk);
    chk(s_axi_rdata, e);
    chk(s_axi_rresp, r);
    s_axi_rready <= 1'b0;
  endtask
  // counts over a window after the new setting has settled
  task automatic delta(input int cyc, input logic [15:0] e);
    logic [15:0] s;
    logic [15:0] d;
    repeat (8) @(posedge clk);
    s = timer_count;
    repeat (cyc) @(posedge clk);
    // kept to 16 bits so a wrap of the count still reads as a step
    d = timer_count - s;
    chk(d, e);
  endtask
  // ==========================================================
  // scenarios
  task automatic t_regs;
    rdchk(`OTC_OFS_CTRL, 32'h0, 32'h0);
    rdchk(`OTC_OFS_COUNT, 32'h0, 32'h0);
    wr(`OTC_OFS_CTRL, 32'hffff_ffff);
    rdchk(`OTC_OFS_CTRL, 32'h0000_a072, 32'h0);
    rdchk(`OTC_OFS_STATUS, 32'h1, 32'h0);
    rdchk(32'hc, 32'h0, `OTC_RESP_SLVERR);
  endtask
  task automatic t_presc;
    for (int i = 0; i < 4; i++) begin
      wr(`OTC_OFS_CTRL, 32'h8000 | (i << 4));
      delta(4 * dv[i], 4);
    end
    chk(timer_active, 1'b1);
  endtask
  task automatic t_modes;
    idle_mode <= 1'b1;
    wr(`OTC_OFS_CTRL, 32'ha000);
    delta(20, 0);
    chk(timer_active, 1'b0);
    wr(`OTC_OFS_CTRL, 32'h8040);
    delta(20, 0);
    gate_pin <= 1'b1;
    delta(20, 20);
    idle_mode <= 1'b0;
    gate_pin <= 1'b0;
    ext_run <= 1'b1;
    wr(`OTC_OFS_CTRL, 32'h8042);
    delta(40, 20);
    wr(`OTC_OFS_CTRL, 32'h8012);
    delta(320, 20);
    ext_run <= 1'b0;
    delta(20, 0);
  endtask
  task automatic t_wide;
    pair_wide_enable <= 1'b1;
    partner_run_on <= 1'b1;
    wr(`OTC_OFS_CTRL, 32'h0);
    delta(20, 20);
    rdchk(`OTC_OFS_STATUS, 32'h3, 32'h0);
    // software keeps halt_in_idle clear so the wide timer runs on in Idle
    idle_mode <= 1'b1;
    delta(20, 20);
    wr(`OTC_OFS_CTRL, 32'h2000);
    delta(20, 0);
    chk(timer_active, 1'b0);
    idle_mode <= 1'b0;
    partner_prescale_select <= 2'h1;
    delta(160, 20);
    partner_gate_accumulate <= 1'b1;
    delta(20, 0);
    {partner_gate_accumulate, partner_prescale_select} <= 3'h0;
    partner_clock_source_select <= 1'b1;
    ext_run <= 1'b1;
    delta(40, 20);
    {ext_run, partner_clock_source_select, partner_run_on} <= 3'h0;
    wr(`OTC_OFS_CTRL, 32'h8000);
    delta(20, 0);
    pair_wide_enable <= 1'b0;
    wr(`OTC_OFS_CTRL, 32'h0);
    wr(`OTC_OFS_COUNT, 32'hfffe);
    delta(20, 0);
    rdchk(`OTC_OFS_COUNT, 32'hfffe, 32'h0);
  endtask
  // reset in mid-run must bring every implemented bit back to zero
  task automatic t_reset;
    wr(`OTC_OFS_CTRL, 32'h8000);
    wr(`OTC_OFS_COUNT, 32'h1234);
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    rdchk(`OTC_OFS_CTRL, 32'h0, 32'h0);
    rdchk(`OTC_OFS_COUNT, 32'h0, 32'h0);
  endtask
  initial begin
    {rst, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h20;
    {idle_mode, gate_pin, pair_wide_enable, ext_run} = 4'h0;
    {partner_run_on, partner_gate_accumulate, partner_clock_source_select} = 3'h0;
    {partner_prescale_select, s_axi_wstrb} = 6'h03;
    {s_axi_awaddr, s_axi_wdata, s_axi_araddr} = '0;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    t_regs();
    t_presc();
    t_modes();
    t_wide();
    t_reset();
    stop_test();
  end
endmodule
